/* src/two_wire_master_pkg.sv */
package two_wire_master_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_START_RX = 12'h000;
  localparam logic [11:0] OFF_START_TX = 12'h008;
  localparam logic [11:0] OFF_HALT = 12'h014;
  localparam logic [11:0] OFF_PAUSE = 12'h01c;
  localparam logic [11:0] OFF_CONTINUE = 12'h020;
  localparam logic [11:0] OFF_HALTED = 12'h104;
  localparam logic [11:0] OFF_RX_FLAG = 12'h108;
  localparam logic [11:0] OFF_TX_FLAG = 12'h11c;
  localparam logic [11:0] OFF_ERR_FLAG = 12'h124;
  localparam logic [11:0] OFF_SUSP_FLAG = 12'h148;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h400;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h404;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h408;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int FLAG_BIT = 0;
  localparam int NUM_EVT = 5;
  localparam int EVT_STOPPED = 0;
  localparam int EVT_RXD = 1;
  localparam int EVT_TXD = 2;
  localparam int EVT_ERR = 3;
  localparam int EVT_SUSP = 4;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [4:0] EVT_RESET = 5'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic start_receive;
    logic start_transmit;
    logic stop;
    logic suspend;
    logic resume;
  } task_t;

  typedef struct packed {
    logic rxByte;
    logic txAck;
    logic readAck;
    logic stopped;
    logic error;
  } eng_evt_t;

  // Bit 0 is the stopped event
  typedef struct packed {
    logic susp;
    logic err;
    logic txd;
    logic rxd;
    logic stopped;
  } evt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX = 2'b01,
    ST_TX = 2'b10,
    ST_SUSP = 2'b11
  } seq_state_t;

endpackage : two_wire_master_pkg

/* src/sticky_flags.sv */
`timescale 1ns/1ps
module sticky_flags #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Set and clear strobes
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  // Flag state
  output logic [N-1:0] flags
);

  logic [N-1:0] flagsD;
  logic [N-1:0] flagsQ;

  // Set wins over a clear in the same cycle
  always_comb begin
    flagsD = (flagsQ & ~clr) | set;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagsQ <= '0;
    end else begin
      flagsQ <= flagsD;
    end
  end

  assign flags = flagsQ;

endmodule : sticky_flags

/* src/txn_sequencer.sv */
`timescale 1ns/1ps
module txn_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Task pulses and engine events
  input two_wire_master_pkg::task_t tasks,
  input two_wire_master_pkg::eng_evt_t eng,
  // Event pulses and bus control
  output two_wire_master_pkg::evt_t evt,
  output two_wire_master_pkg::seq_state_t state,
  output logic holdBus,
  output logic nackNext
);

  two_wire_master_pkg::seq_state_t stateD, stateQ;
  two_wire_master_pkg::evt_t evtD, evtQ;
  logic rxDirD, rxDirQ;
  logic suspReqD, suspReqQ;
  logic nackD, nackQ;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    stateD = stateQ;
    rxDirD = rxDirQ;
    suspReqD = suspReqQ;
    nackD = nackQ;
    evtD = '0;
    if (tasks.start_receive) begin
      stateD = two_wire_master_pkg::ST_RX;
      rxDirD = 1'b1;
      suspReqD = 1'b0;
      nackD = (stateQ == two_wire_master_pkg::ST_RX);
    end else if (tasks.start_transmit) begin
      stateD = two_wire_master_pkg::ST_TX;
      rxDirD = 1'b0;
      suspReqD = 1'b0;
      nackD = (stateQ == two_wire_master_pkg::ST_RX);
    end
    if (tasks.stop && stateQ == two_wire_master_pkg::ST_RX) begin
      nackD = 1'b1;
    end
    if (tasks.suspend && (stateQ == two_wire_master_pkg::ST_RX ||
        stateQ == two_wire_master_pkg::ST_TX)) begin
      suspReqD = 1'b1;
    end
    if (tasks.resume && stateQ == two_wire_master_pkg::ST_SUSP) begin
      stateD = rxDirQ ? two_wire_master_pkg::ST_RX
                      : two_wire_master_pkg::ST_TX;
    end
    if (eng.readAck && stateQ == two_wire_master_pkg::ST_RX) begin
      nackD = 1'b0;
      if (suspReqQ) begin
        stateD = two_wire_master_pkg::ST_SUSP;
        suspReqD = 1'b0;
        evtD.susp = 1'b1;
      end
    end
    if (eng.txAck && stateQ == two_wire_master_pkg::ST_TX) begin
      evtD.txd = 1'b1;
      if (suspReqQ) begin
        stateD = two_wire_master_pkg::ST_SUSP;
        suspReqD = 1'b0;
        evtD.susp = 1'b1;
      end
    end
    if (eng.rxByte && stateQ == two_wire_master_pkg::ST_RX) begin
      evtD.rxd = 1'b1;
    end
    if (eng.error) begin
      evtD.err = 1'b1;
    end
    if (eng.stopped) begin
      stateD = two_wire_master_pkg::ST_IDLE;
      suspReqD = 1'b0;
      nackD = 1'b0;
      evtD.stopped = 1'b1;
      // A stop in the same cycle leaves nothing suspended
      evtD.susp = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= two_wire_master_pkg::ST_IDLE;
      rxDirQ <= 1'b0;
      suspReqQ <= 1'b0;
      nackQ <= 1'b0;
      evtQ <= '0;
    end else begin
      stateQ <= stateD;
      rxDirQ <= rxDirD;
      suspReqQ <= suspReqD;
      nackQ <= nackD;
      evtQ <= evtD;
    end
  end

  assign evt = evtQ;
  assign state = stateQ;
  assign holdBus = (stateQ == two_wire_master_pkg::ST_SUSP);
  assign nackNext = nackQ;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_sent_after_ack: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    evtQ.txd |-> $past(eng.txAck) &&
      $past(stateQ) == two_wire_master_pkg::ST_TX)
    else $error("byte sent without acknowledge in transmit");

  a_suspend_event: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    evtQ.susp |-> $past(suspReqQ) && holdBus)
    else $error("suspended event without earlier request");

endmodule : txn_sequencer

/* src/two_wire_master_task_event_regs.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - Writing one to start-receive begins a bus read; write-only, resets zero.
// - Writing one to start-transmit begins a bus write; write-only.
// - Writing one to the halt trigger ends the ongoing transaction.
// - Writing one to the pause trigger suspends the ongoing transaction.
// - Writing one to the continue trigger resumes a suspended transaction.
// - Halted flag bit 0 sets when the transaction stops; read-write.
// - Byte-received flag sets each time a byte lands in receive data.
// - Byte-sent flag sets each time a transmit byte went out.
// - Bus-error flag sets on a bus error; read-write, resets zero.
// - Byte-sent fires only after the byte and its acknowledge bit.
// - Suspended event fires after a read or transmit acknowledge, only if requested.
module two_wire_master_task_event_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input two_wire_master_pkg::reg_req_t req,
  output logic [31:0] rdata,
  // Bus engine
  output two_wire_master_pkg::task_t tasks,
  input two_wire_master_pkg::eng_evt_t eng,
  output logic holdBus,
  output logic nackNext,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic hit(
    input logic [11:0] a,
    input logic [11:0] off
  );
    return a == off;
  endfunction : hit

  function automatic logic [11:0] evtOff(input int idx);
    logic [11:0] off;
    off = two_wire_master_pkg::OFF_HALTED;
    unique case (idx)
      two_wire_master_pkg::EVT_STOPPED: begin
        off = two_wire_master_pkg::OFF_HALTED;
      end
      two_wire_master_pkg::EVT_RXD: begin
        off = two_wire_master_pkg::OFF_RX_FLAG;
      end
      two_wire_master_pkg::EVT_TXD: begin
        off = two_wire_master_pkg::OFF_TX_FLAG;
      end
      two_wire_master_pkg::EVT_ERR: begin
        off = two_wire_master_pkg::OFF_ERR_FLAG;
      end
      default: begin
        off = two_wire_master_pkg::OFF_SUSP_FLAG;
      end
    endcase
    return off;
  endfunction : evtOff

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  two_wire_master_pkg::task_t tasksD, tasksQ;
  two_wire_master_pkg::evt_t evt;
  two_wire_master_pkg::seq_state_t busState;
  logic [4:0] evtSet;
  logic [4:0] evtClr;
  logic [4:0] evtFlags;
  logic [4:0] irqClr;
  logic [4:0] irqStat;
  logic [4:0] enD, enQ;
  logic [31:0] rdataD, rdataQ;
  logic wrOne;

  // ----------------------------------------
  // Task triggers
  // ----------------------------------------
  assign wrOne = req.wr && req.wdata[two_wire_master_pkg::FLAG_BIT];

  always_comb begin
    tasksD = '0;
    if (wrOne) begin
      tasksD.start_receive = hit(req.addr,
        two_wire_master_pkg::OFF_START_RX);
      tasksD.start_transmit = hit(req.addr,
        two_wire_master_pkg::OFF_START_TX);
      tasksD.stop = hit(req.addr,
        two_wire_master_pkg::OFF_HALT);
      tasksD.suspend = hit(req.addr,
        two_wire_master_pkg::OFF_PAUSE);
      tasksD.resume = hit(req.addr,
        two_wire_master_pkg::OFF_CONTINUE);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tasksQ <= '0;
    end else begin
      tasksQ <= tasksD;
    end
  end

  assign tasks = tasksQ;

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  txn_sequencer u_seq (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tasks(tasksQ),
    .eng(eng),
    .evt(evt),
    .state(busState),
    .holdBus(holdBus),
    .nackNext(nackNext)
  );

  // ----------------------------------------
  // Event flag registers
  // ----------------------------------------
  always_comb begin
    evtSet = evt;
    evtClr = '0;
    for (int i = 0; i < two_wire_master_pkg::NUM_EVT; i++) begin
      if (req.wr && hit(req.addr, evtOff(i))) begin
        evtSet[i] = evt[i] | req.wdata[two_wire_master_pkg::FLAG_BIT];
        evtClr[i] = ~req.wdata[two_wire_master_pkg::FLAG_BIT];
      end
    end
  end

  sticky_flags #(
    .N(two_wire_master_pkg::NUM_EVT)
  ) u_evt_flags (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .set(evtSet),
    .clr(evtClr),
    .flags(evtFlags)
  );

  // ----------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------
  always_comb begin
    enD = enQ;
    irqClr = '0;
    if (req.wr && hit(req.addr, two_wire_master_pkg::OFF_IRQ_ENABLE)) begin
      enD = req.wdata[4:0];
    end
    if (req.wr && hit(req.addr, two_wire_master_pkg::OFF_IRQ_CLEAR)) begin
      irqClr = req.wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      enQ <= two_wire_master_pkg::EVT_RESET;
    end else begin
      enQ <= enD;
    end
  end

  sticky_flags #(
    .N(two_wire_master_pkg::NUM_EVT)
  ) u_irq_status (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .set(evt),
    .clr(irqClr),
    .flags(irqStat)
  );

  assign irq = |(irqStat & enQ);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdataD = two_wire_master_pkg::RDATA_RESET;
    if (req.rd) begin
      for (int i = 0; i < two_wire_master_pkg::NUM_EVT; i++) begin
        if (hit(req.addr, evtOff(i))) begin
          rdataD[two_wire_master_pkg::FLAG_BIT] = evtFlags[i];
        end
      end
      if (hit(req.addr, two_wire_master_pkg::OFF_IRQ_STATUS)) begin
        rdataD[4:0] = irqStat;
      end
      if (hit(req.addr, two_wire_master_pkg::OFF_IRQ_ENABLE)) begin
        rdataD[4:0] = enQ;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdataQ <= two_wire_master_pkg::RDATA_RESET;
    end else begin
      rdataQ <= rdataD;
    end
  end

  assign rdata = rdataQ;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_start_rx_pulse: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wrOne && hit(req.addr, two_wire_master_pkg::OFF_START_RX))
      |=> tasks.start_receive ##1 !tasks.start_receive || tasksD.start_receive)
    else $error("start receive not pulsed");

  a_start_tx_pulse: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wrOne && hit(req.addr, two_wire_master_pkg::OFF_START_TX))
      |=> tasks.start_transmit && !tasks.start_receive)
    else $error("start transmit not pulsed");

  a_halt_pulse: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    tasks.stop |-> $past(req.wr) &&
      $past(req.addr) == two_wire_master_pkg::OFF_HALT)
    else $error("halt pulse without halt write");

  a_pause_pulse: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wrOne && hit(req.addr, two_wire_master_pkg::OFF_PAUSE))
      |=> tasks.suspend)
    else $error("pause not pulsed");

  a_continue_pulse: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (tasks.resume && busState == two_wire_master_pkg::ST_SUSP)
      |=> busState != two_wire_master_pkg::ST_SUSP || $past(evt.susp))
    else $error("continue did not leave suspend");

  a_halted_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    evt.stopped |=> evtFlags[two_wire_master_pkg::EVT_STOPPED] &&
      irqStat[two_wire_master_pkg::EVT_STOPPED])
    else $error("halted flag not set");

  a_rx_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    evt.rxd |=> evtFlags[two_wire_master_pkg::EVT_RXD])
    else $error("byte received flag not set");

  a_tx_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    evt.txd |=> evtFlags[two_wire_master_pkg::EVT_TXD])
    else $error("byte sent flag not set");

  a_error_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    eng.error |=> ##1 evtFlags[two_wire_master_pkg::EVT_ERR])
    else $error("error flag not set two cycles after error");

  a_trigger_reads: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (req.rd && (hit(req.addr, two_wire_master_pkg::OFF_START_RX) ||
      hit(req.addr, two_wire_master_pkg::OFF_HALT)))
      |=> rdata == two_wire_master_pkg::RDATA_RESET)
    else $error("trigger read not zero");

  a_zero_write: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (req.wr && !req.wdata[two_wire_master_pkg::FLAG_BIT])
      |=> tasks == '0)
    else $error("zero write fired a task");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (|(evt & enD)) |=> irq)
    else $error("enabled event did not raise interrupt");

  a_rdata_idle: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !req.rd |=> rdata == two_wire_master_pkg::RDATA_RESET)
    else $error("read data not zero outside a read");

  a_halted_clear: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (req.wr && hit(req.addr, two_wire_master_pkg::OFF_HALTED) &&
      !req.wdata[two_wire_master_pkg::FLAG_BIT] && !evt.stopped)
      |=> !evtFlags[two_wire_master_pkg::EVT_STOPPED])
    else $error("halted flag not cleared by zero write");

  a_rx_flag_read: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (req.rd && hit(req.addr, two_wire_master_pkg::OFF_RX_FLAG))
      |=> rdata[two_wire_master_pkg::FLAG_BIT] ==
      $past(evtFlags[two_wire_master_pkg::EVT_RXD]))
    else $error("byte received flag read back wrong");

endmodule : two_wire_master_task_event_regs

/* verification/engine_model.sv */
`timescale 1ns/1ps
module engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Design side
  input two_wire_master_pkg::task_t tasks,
  input wire logic holdBus,
  // Bench commands
  input wire logic byteReq,
  input wire logic errReq,
  // Engine events
  output two_wire_master_pkg::eng_evt_t eng
);
  // ----------------------------------------
  // Byte and stop timing
  // ----------------------------------------
  logic [1:0] dir_q;
  logic [2:0] byteCnt_q;
  logic [1:0] stopCnt_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_q <= 2'h0;
      byteCnt_q <= 3'h0;
      stopCnt_q <= 2'h0;
      eng <= '0;
    end else begin
      eng <= '0;
      if (tasks.start_receive) begin
        dir_q <= 2'h1;
      end
      if (tasks.start_transmit) begin
        dir_q <= 2'h2;
      end
      if (tasks.stop) begin
        stopCnt_q <= 2'h3;
      end else if (stopCnt_q != 2'h0) begin
        stopCnt_q <= stopCnt_q - 2'h1;
      end
      if (stopCnt_q == 2'h1) begin
        eng.stopped <= 1'h1;
        dir_q <= 2'h0;
      end
      // Suspended bus is stretched: no byte moves
      if (byteReq && !holdBus) begin
        byteCnt_q <= 3'h4;
      end else if (byteCnt_q != 3'h0) begin
        byteCnt_q <= byteCnt_q - 3'h1;
      end
      if (byteCnt_q == 3'h2 && dir_q == 2'h1) begin
        eng.rxByte <= 1'h1;
      end
      // Acknowledge bit follows each byte
      if (byteCnt_q == 3'h1) begin
        eng.readAck <= (dir_q == 2'h1);
        eng.txAck <= (dir_q == 2'h2);
      end
      if (errReq) begin
        eng.error <= 1'h1;
      end
    end
  end
endmodule : engine_model

/* verification/two_wire_master_task_event_regs_tb_top.sv */
`timescale 1ns/1ps
module two_wire_master_task_event_regs_tb_top;
  logic sys_clk;
  logic arst_n;
  two_wire_master_pkg::reg_req_t req;
  logic [31:0] rdata;
  two_wire_master_pkg::task_t tasks;
  two_wire_master_pkg::eng_evt_t eng;
  logic holdBus;
  logic nackNext;
  logic irq;
  logic byteReq;
  logic errReq;
  logic [31:0] rd;
  int errors;
  int num_checks;
  logic [11:0] offs [9];

  two_wire_master_task_event_regs two_wire_master_task_event_regs_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .req(req),
    .rdata(rdata),
    .tasks(tasks),
    .eng(eng),
    .holdBus(holdBus),
    .nackNext(nackNext),
    .irq(irq)
  );

  engine_model engine_model_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tasks(tasks),
    .holdBus(holdBus),
    .byteReq(byteReq),
    .errReq(errReq),
    .eng(eng)
  );

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'h1;
    @(posedge sys_clk);
    req.wr <= 1'h0;
  endtask : regWrite

  task automatic regRead(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge sys_clk);
    req.rd <= 1'h0;
    #1;
    d = rdata;
  endtask : regRead

  task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : checkReg

  task automatic checkPin(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask : checkPin

  // Pulse on tasks one cycle after the write, gone a cycle later
  task automatic trig(input logic [11:0] a, input logic [31:0] d,
                      input logic [4:0] exp);
    regWrite(a, d);
    #1;
    checkPin(tasks, exp);
    @(posedge sys_clk);
    #1;
    checkPin(tasks, 5'h00);
  endtask : trig

  task automatic pollFlag(input logic [11:0] a);
    for (int i = 0; i < 20; i++) begin
      regRead(a, rd);
      if (rd[0] === 1'h1) begin
        break;
      end
    end
    checkReg(rd, 32'h1);
  endtask : pollFlag

  task automatic sendByte();
    @(posedge sys_clk);
    byteReq <= 1'h1;
    @(posedge sys_clk);
    byteReq <= 1'h0;
  endtask : sendByte

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    sys_clk = 1'h0;
    arst_n = 1'h0;
    req = '0;
    byteReq = 1'h0;
    errReq = 1'h0;
    errors = 0;
    num_checks = 0;
    offs = '{two_wire_master_pkg::OFF_START_RX,
      two_wire_master_pkg::OFF_START_TX, two_wire_master_pkg::OFF_HALT,
      two_wire_master_pkg::OFF_PAUSE, two_wire_master_pkg::OFF_CONTINUE,
      two_wire_master_pkg::OFF_HALTED, two_wire_master_pkg::OFF_RX_FLAG,
      two_wire_master_pkg::OFF_TX_FLAG, two_wire_master_pkg::OFF_ERR_FLAG};
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'h1;
    foreach (offs[i]) begin
      regRead(offs[i], rd);
      checkReg(rd, 32'h0);
    end
    regWrite(12'h500, 32'h1);
    regRead(12'h500, rd);
    checkReg(rd, 32'h0);
    regWrite(two_wire_master_pkg::OFF_IRQ_ENABLE, 32'h1f);
    // Transmit, byte sent, suspend and resume
    trig(two_wire_master_pkg::OFF_START_TX, 32'h0, 5'h00);
    trig(two_wire_master_pkg::OFF_START_TX, 32'h1, 5'h08);
    regRead(two_wire_master_pkg::OFF_START_TX, rd);
    checkReg(rd, 32'h0);
    regRead(two_wire_master_pkg::OFF_TX_FLAG, rd);
    checkReg(rd, 32'h0);
    sendByte();
    pollFlag(two_wire_master_pkg::OFF_TX_FLAG);
    trig(two_wire_master_pkg::OFF_PAUSE, 32'h1, 5'h02);
    sendByte();
    pollFlag(two_wire_master_pkg::OFF_SUSP_FLAG);
    checkPin({4'h0, holdBus}, 5'h01);
    trig(two_wire_master_pkg::OFF_CONTINUE, 32'h1, 5'h01);
    checkPin({4'h0, holdBus}, 5'h00);
    trig(two_wire_master_pkg::OFF_HALT, 32'h1, 5'h04);
    pollFlag(two_wire_master_pkg::OFF_HALTED);
    checkPin({4'h0, irq}, 5'h01);
    regWrite(two_wire_master_pkg::OFF_HALTED, 32'h0);
    regRead(two_wire_master_pkg::OFF_HALTED, rd);
    checkReg(rd, 32'h0);
    regWrite(two_wire_master_pkg::OFF_IRQ_CLEAR, 32'h1f);
    #1;
    checkPin({4'h0, irq}, 5'h00);
    // Masked error, then unmasked
    regWrite(two_wire_master_pkg::OFF_IRQ_ENABLE, 32'h0);
    @(posedge sys_clk);
    errReq <= 1'h1;
    @(posedge sys_clk);
    errReq <= 1'h0;
    pollFlag(two_wire_master_pkg::OFF_ERR_FLAG);
    checkPin({4'h0, irq}, 5'h00);
    regRead(two_wire_master_pkg::OFF_IRQ_STATUS, rd);
    checkReg(rd, 32'h08);
    regWrite(two_wire_master_pkg::OFF_IRQ_ENABLE, 32'h08);
    #1;
    checkPin({4'h0, irq}, 5'h01);
    regWrite(two_wire_master_pkg::OFF_IRQ_CLEAR, 32'h08);
    #1;
    checkPin({4'h0, irq}, 5'h00);
    // Receive, suspend after read ack, stop with not-acknowledge
    trig(two_wire_master_pkg::OFF_START_RX, 32'h1, 5'h10);
    sendByte();
    pollFlag(two_wire_master_pkg::OFF_RX_FLAG);
    regWrite(two_wire_master_pkg::OFF_SUSP_FLAG, 32'h0);
    trig(two_wire_master_pkg::OFF_PAUSE, 32'h1, 5'h02);
    sendByte();
    pollFlag(two_wire_master_pkg::OFF_SUSP_FLAG);
    checkPin({4'h0, holdBus}, 5'h01);
    trig(two_wire_master_pkg::OFF_CONTINUE, 32'h1, 5'h01);
    trig(two_wire_master_pkg::OFF_HALT, 32'h1, 5'h04);
    checkPin({4'h0, nackNext}, 5'h01);
    sendByte();
    pollFlag(two_wire_master_pkg::OFF_HALTED);
    checkPin({4'h0, nackNext}, 5'h00);
    // Repeated start in a read, cleared by the read acknowledge
    regWrite(two_wire_master_pkg::OFF_RX_FLAG, 32'h0);
    trig(two_wire_master_pkg::OFF_START_RX, 32'h1, 5'h10);
    trig(two_wire_master_pkg::OFF_START_RX, 32'h1, 5'h10);
    checkPin({4'h0, nackNext}, 5'h01);
    sendByte();
    pollFlag(two_wire_master_pkg::OFF_RX_FLAG);
    checkPin({4'h0, nackNext}, 5'h00);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : two_wire_master_task_event_regs_tb_top
